// [include/adcpt_pkg.sv]
// Constants and carriers for the ADC phase timing block.
// Assumes a 32-bit classic Wishbone bus, bytes in lane 0.
package adcpt_pkg;
  // ==============================================
  // Register indexes (byte address = 4 * index)
  localparam logic [13:0] IDX_FLT_L = 14'h1D14;
  localparam logic [13:0] IDX_FLT_H = 14'h1D15;
  localparam logic [13:0] IDX_CNT = 14'h1D19;
  localparam logic [13:0] IDX_RPT = 14'h1D1A;
  localparam logic [13:0] IDX_PREV_L = 14'h1D1B;
  localparam logic [13:0] IDX_PREV_H = 14'h1D1C;
  localparam logic [13:0] IDX_RES_L = 14'h1D1D;
  localparam logic [13:0] IDX_RES_H = 14'h1D1E;
  localparam logic [13:0] IDX_ACQ_L = 14'h1D21;
  localparam logic [13:0] IDX_ACQ_H = 14'h1D22;
  localparam logic [13:0] IDX_CAP = 14'h1D23;
  localparam logic [13:0] IDX_PRE_L = 14'h1D24;
  localparam logic [13:0] IDX_PRE_H = 14'h1D25;
  localparam logic [13:0] IDX_CLKDIV = 14'h1D2D;
  localparam logic [13:0] IDX_CTRL = 14'h1D30;
  localparam logic [13:0] IDX_COMP = 14'h1D31;
  localparam logic [13:0] IDX_STAT = 14'h1D32;
  localparam logic [13:0] IDX_INT_ST = 14'h1D33;
  localparam logic [13:0] IDX_INT_CLR = 14'h1D34;
  localparam logic [13:0] IDX_INT_EN = 14'h1D35;
  // ==============================================
  // Field positions
  localparam int CTRL_GO = 0;
  localparam int CTRL_RC = 1;
  localparam int CTRL_PRIOR_SOURCE_SEL = 2;
  localparam int CTRL_FMT = 3;
  localparam int INT_DONE = 0;
  localparam int INT_THR = 1;
  localparam logic [13:0] ACQ_DEFAULT = 14'h2000;
  // ==============================================
  // Types
  typedef enum logic [2:0] {
    MODE_BASIC, MODE_ACCUM, MODE_AVG, MODE_BURST, MODE_LPF
  } adcpt_mode_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [15:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
  } adcpt_wb_req_t;
  typedef struct packed {
    logic precharge;
    logic acquire;
    logic convert_start;
    logic adc_clk_tick;
    logic [4:0] added_load;
  } adcpt_ana_t;
endpackage

// [core/adcpt_core.sv]
// ADC phase timing, repeat tally and result capture.
// Assumes a Wishbone master, an analog core on the same
// clock and an asynchronous RC oscillator pin.
`timescale 1ns/100ps
`default_nettype none
module adcpt_core
  import adcpt_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Wishbone slave
  input wire adcpt_wb_req_t wb_req,
  output logic ack_o,
  output logic [31:0] dat_o,
  // Analog core
  input wire logic trigger_i,
  input wire logic conv_done_i,
  input wire logic [9:0] conv_data_i,
  input wire logic rc_osc_pin,
  output adcpt_ana_t ana,
  // Interrupt
  output logic irq
);
  // ==============================================
  // Registers
  typedef enum logic [2:0] {
    ST_IDLE, ST_PRE, ST_ACQ, ST_START, ST_WAIT
  } adcpt_state_t;
  adcpt_state_t state;
  logic [12:0] pre;
  logic [12:0] sampling_window;
  logic [4:0] cap;
  logic [7:0] repeat_threshold;
  logic [7:0] tally;
  logic [15:0] res;
  logic [15:0] prev;
  logic [15:0] filt;
  logic signed [17:0] acc;
  logic [5:0] clk_div;
  logic ctl_rc;
  logic ctl_prior_source_sel;
  logic ctl_fmt;
  logic [2:0] mode;
  logic [2:0] shift;
  logic [1:0] int_st;
  logic [1:0] int_en;
  logic [13:0] cnt;
  logic [6:0] div_cnt;
  logic rc_s1;
  logic rc_s2;
  logic rc_s3;
  logic burst_pend;
  // ==============================================
  // Bus decode
  logic req;
  logic wr;
  logic [13:0] idx;
  logic [7:0] wd;
  logic [7:0] rd_byte;
  logic go_req;
  assign req = wb_req.cyc & wb_req.stb;
  assign wr = req & wb_req.we & ~ack_o & wb_req.sel[0];
  assign idx = wb_req.adr[15:2];
  assign wd = wb_req.dat[7:0];
  assign go_req = wr && idx == IDX_CTRL && wd[CTRL_GO];
  // ==============================================
  // Derived terms
  logic rc_tick;
  logic tick;
  logic start;
  logic done;
  logic tmode;
  logic check;
  logic [15:0] fmt_val;
  logic signed [17:0] raw_ext;
  logic signed [17:0] acc_sh;
  assign rc_tick = rc_s2 & ~rc_s3;
  assign tick = ctl_rc ? rc_tick : 1'b1;
  assign start = state == ST_IDLE &&
    (trigger_i | go_req | burst_pend);
  assign done = state == ST_WAIT && conv_done_i;
  assign tmode = mode == MODE_AVG || mode == MODE_BURST ||
    mode == MODE_LPF;
  assign check = done && tmode && tally == repeat_threshold;
  assign fmt_val = ctl_fmt ? {conv_data_i, 6'h00}
    : {6'h00, conv_data_i};
  assign raw_ext = $signed({8'h00, conv_data_i});
  assign acc_sh = acc >>> shift;
  // ==============================================
  // RC oscillator synchroniser
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rc_s1 <= 1'b0;
      rc_s2 <= 1'b0;
      rc_s3 <= 1'b0;
    end else begin
      rc_s1 <= rc_osc_pin;
      rc_s2 <= rc_s1;
      rc_s3 <= rc_s2;
    end
  end
  // ==============================================
  // Converter clock divider
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= 7'h00;
      ana.adc_clk_tick <= 1'b0;
    end else if (ctl_rc) begin
      // Divider bypassed on the RC source
      div_cnt <= 7'h00;
      ana.adc_clk_tick <= rc_tick;
    end else if (div_cnt == {clk_div, 1'b1}) begin
      div_cnt <= 7'h00;
      ana.adc_clk_tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 7'h01;
      ana.adc_clk_tick <= 1'b0;
    end
  end
  // ==============================================
  // Phase sequencer
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      cnt <= 14'h0000;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (start) begin
            if (pre != 13'h0000) begin
              state <= ST_PRE;
              cnt <= {1'b0, pre};
            end else if (sampling_window != 13'h0000) begin
              state <= ST_ACQ;
              cnt <= {1'b0, sampling_window};
            end else begin
              state <= ST_START;
            end
          end
        end
        ST_PRE: begin
          if (tick && cnt == 14'h0001) begin
            state <= ST_ACQ;
            if (sampling_window == 13'h0000) begin
              cnt <= ACQ_DEFAULT;
            end else begin
              cnt <= {1'b0, sampling_window};
            end
          end else if (tick) begin
            cnt <= cnt - 14'h0001;
          end
        end
        ST_ACQ: begin
          if (tick && cnt == 14'h0001) begin
            state <= ST_START;
          end else if (tick) begin
            cnt <= cnt - 14'h0001;
          end
        end
        ST_START: begin
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          if (conv_done_i) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end
  // ==============================================
  // Analog control outputs, one cycle behind state; added_load one cycle behind cap
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ana.precharge <= 1'b0;
      ana.acquire <= 1'b0;
      ana.convert_start <= 1'b0;
      ana.added_load <= 5'h00;
    end else begin
      ana.precharge <= state == ST_PRE;
      ana.acquire <= state == ST_ACQ;
      ana.convert_start <= state == ST_START;
      ana.added_load <= cap;
    end
  end
  // ==============================================
  // Burst retrigger until the group is checked
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      burst_pend <= 1'b0;
    end else begin
      burst_pend <= done && mode == MODE_BURST && !check;
    end
  end
  // ==============================================
  // Trigger tally
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tally <= 8'h00;
    end else if (check) begin
      tally <= 8'h00;
    end else if (start && tmode && tally != 8'hFF) begin
      tally <= tally + 8'h01;
    end else if (wr && idx == IDX_CNT) begin
      tally <= wd;
    end
  end
  // ==============================================
  // Running sum and filtered value
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      acc <= 18'sh00000;
    end else if (done) begin
      unique case (mode)
        MODE_ACCUM: acc <= acc + raw_ext;
        MODE_AVG, MODE_BURST: begin
          // First sample of a group restarts the sum
          acc <= tally == 8'h01 ? raw_ext : acc + raw_ext;
        end
        MODE_LPF: acc <= acc + raw_ext - acc_sh;
        default: acc <= acc;
      endcase
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      filt <= 16'h0000;
    end else begin
      filt <= acc_sh[15:0];
    end
  end
  // ==============================================
  // Result and prior value
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      res <= 16'h0000;
    end else if (done) begin
      res <= fmt_val;
    end else if (wr && idx == IDX_RES_L) begin
      res[7:0] <= wd;
    end else if (wr && idx == IDX_RES_H) begin
      res[15:8] <= wd;
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prev <= 16'h0000;
    end else if (start) begin
      // Result is already justified, so prev matches it when ctl_prior_source_sel is 0; when it is 1, prev takes filt
      prev <= ctl_prior_source_sel ? filt : res;
    end
  end
  // ==============================================
  // Configuration registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pre <= 13'h0000;
      sampling_window <= 13'h0000;
      cap <= 5'h00;
      repeat_threshold <= 8'h00;
      clk_div <= 6'h00;
      ctl_rc <= 1'b0;
      ctl_prior_source_sel <= 1'b0;
      ctl_fmt <= 1'b0;
      mode <= 3'h0;
      shift <= 3'h0;
      int_en <= 2'h0;
    end else if (wr) begin
      unique case (idx)
        IDX_PRE_L: pre[7:0] <= wd;
        IDX_PRE_H: pre[12:8] <= wd[4:0];
        IDX_ACQ_L: sampling_window[7:0] <= wd;
        IDX_ACQ_H: sampling_window[12:8] <= wd[4:0];
        IDX_CAP: cap <= wd[4:0];
        IDX_RPT: repeat_threshold <= wd;
        IDX_CLKDIV: clk_div <= wd[5:0];
        IDX_CTRL: begin
          ctl_rc <= wd[CTRL_RC];
          ctl_prior_source_sel <= wd[CTRL_PRIOR_SOURCE_SEL];
          ctl_fmt <= wd[CTRL_FMT];
        end
        IDX_COMP: begin
          mode <= wd[2:0];
          shift <= wd[6:4];
        end
        IDX_INT_EN: int_en <= wd[1:0];
        default: mode <= mode;
      endcase
    end
  end
  // ==============================================
  // Interrupt status, set wins over clear
  logic [1:0] clr_mask;
  logic [1:0] evt;
  assign clr_mask = (wr && idx == IDX_INT_CLR) ? wd[1:0]
    : 2'h0;
  assign evt = {check, done};
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      int_st <= 2'h0;
      irq <= 1'b0;
    end else begin
      int_st <= (int_st & ~clr_mask) | evt;
      irq <= |(int_st & int_en);
    end
  end
  // ==============================================
  // Read mux
  always_comb begin
    rd_byte = 8'h00;
    unique case (idx)
      IDX_FLT_L: rd_byte = filt[7:0];
      IDX_FLT_H: rd_byte = filt[15:8];
      IDX_CNT: rd_byte = tally;
      IDX_RPT: rd_byte = repeat_threshold;
      IDX_PREV_L: rd_byte = prev[7:0];
      IDX_PREV_H: rd_byte = prev[15:8];
      IDX_RES_L: rd_byte = res[7:0];
      IDX_RES_H: rd_byte = res[15:8];
      IDX_ACQ_L: rd_byte = sampling_window[7:0];
      IDX_ACQ_H: rd_byte = {3'h0, sampling_window[12:8]};
      IDX_CAP: rd_byte = {3'h0, cap};
      IDX_PRE_L: rd_byte = pre[7:0];
      IDX_PRE_H: rd_byte = {3'h0, pre[12:8]};
      IDX_CLKDIV: rd_byte = {2'h0, clk_div};
      IDX_CTRL: begin
        rd_byte = {4'h0, ctl_fmt, ctl_prior_source_sel, ctl_rc,
          state != ST_IDLE};
      end
      IDX_COMP: rd_byte = {1'b0, shift, 1'b0, mode};
      IDX_STAT: rd_byte = {5'h00, state};
      IDX_INT_ST: rd_byte = {6'h00, int_st};
      IDX_INT_EN: rd_byte = {6'h00, int_en};
      default: rd_byte = 8'h00;
    endcase
  end
  // ==============================================
  // Bus answer, one wait state, unmapped reads zero
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req & ~ack_o;
      if (req && !ack_o) begin
        dat_o <= {24'h000000, rd_byte};
      end
    end
  end
  // ==============================================
  // Checks
  property p_pre_skip;
    @(posedge clock) disable iff (!rst_b)
    start && pre == 13'h0000 |=> state != ST_PRE;
  endproperty
  a_pre_skip: assert property (p_pre_skip)
    else $error("precharge not skipped");
  property p_pre_len;
    @(posedge clock) disable iff (!rst_b)
    start && pre != 13'h0000 |=>
      state == ST_PRE && cnt == {1'b0, $past(pre)};
  endproperty
  a_pre_len: assert property (p_pre_len)
    else $error("precharge length wrong");
  property p_acq_len;
    @(posedge clock) disable iff (!rst_b)
    start && pre == 13'h0000 && sampling_window != 13'h0000 |=>
      state == ST_ACQ && cnt == {1'b0, $past(sampling_window)};
  endproperty
  a_acq_len: assert property (p_acq_len)
    else $error("acquisition length wrong");
  property p_acq_default;
    @(posedge clock) disable iff (!rst_b)
    state == ST_PRE && tick && cnt == 14'h0001 &&
      sampling_window == 13'h0000 |=> state == ST_ACQ && cnt == 14'h2000;
  endproperty
  a_acq_default: assert property (p_acq_default)
    else $error("acquisition default not 8192");
  property p_tally_restart;
    @(posedge clock) disable iff (!rst_b)
    check |=> tally == 8'h00 && int_st[INT_THR];
  endproperty
  a_tally_restart: assert property (p_tally_restart)
    else $error("tally not restarted");
  property p_tally_mode;
    @(posedge clock) disable iff (!rst_b)
    start && !tmode && !(wr && idx == IDX_CNT) |=>
      $stable(tally);
  endproperty
  a_tally_mode: assert property (p_tally_mode)
    else $error("tally moved outside filter modes");
  property p_prev_src;
    @(posedge clock) disable iff (!rst_b)
    start |=> prev == ($past(ctl_prior_source_sel) ? $past(filt)
      : $past(res));
  endproperty
  a_prev_src: assert property (p_prev_src)
    else $error("prior value capture wrong");
  property p_res_cap;
    @(posedge clock) disable iff (!rst_b)
    done |=> res == $past(fmt_val);
  endproperty
  a_res_cap: assert property (p_res_cap)
    else $error("result not captured");
  property p_load;
    @(posedge clock) disable iff (!rst_b)
    ##1 ana.added_load == $past(cap);
  endproperty
  a_load: assert property (p_load)
    else $error("added load mismatch");
  property p_filt;
    @(posedge clock) disable iff (!rst_b)
    done ##1 1'b1 |=> filt == $past(acc_sh[15:0]);
  endproperty
  a_filt: assert property (p_filt)
    else $error("filtered value stale");
  property p_irq;
    @(posedge clock) disable iff (!rst_b)
    |(int_st & int_en) |=> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt not raised");
endmodule // adcpt_core
`default_nettype wire

// [bench/adcpt_ana_model.sv]
// Analog core stand-in: answers each convert start
// with a sample after a delay that the bench sets.
`timescale 1ns/100ps
`default_nettype none
module adcpt_ana_model
  import adcpt_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // From the block and the bench
  input wire adcpt_ana_t ana,
  input wire logic [7:0] lat,
  input wire logic [9:0] sample,
  // To the block
  output logic conv_done_i,
  output logic [9:0] conv_data_i
);
  // ==========
  // Conversion timer
  logic busy;
  logic [7:0] cnt;
  // Data toggles outside the pulse, so stale bits never match
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
      cnt <= 8'h00;
      conv_done_i <= 1'b0;
      conv_data_i <= 10'h155;
    end else begin
      conv_done_i <= 1'b0;
      conv_data_i <= ~conv_data_i;
      if (ana.convert_start) begin
        busy <= 1'b1;
        cnt <= lat;
      end else if (busy && cnt == 8'h00) begin
        busy <= 1'b0;
        conv_done_i <= 1'b1;
        conv_data_i <= sample;
      end else if (busy) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule // adcpt_ana_model
`default_nettype wire

// [bench/adcpt_core_tb.sv]
// Bench for adcpt_core: bus tasks, phase counts, checks.
// Assumes adcpt_ana_model on the analog side.
`timescale 1ns/100ps
`default_nettype none
module adcpt_core_tb
  import adcpt_pkg::*;
;
  // ==========
  // Signals
  logic clock, rst_b, ack_o, trigger_i, conv_done_i, rc_osc_pin, irq;
  logic bad = 1'b0;
  logic seen = 1'b0;
  logic [31:0] dat_o;
  logic [31:0] seed = 32'h00007102;
  logic [9:0] conv_data_i, sample;
  logic [7:0] lat, ctl, q;
  logic [15:0] f, ef, lres, v;
  logic signed [17:0] acc;
  adcpt_wb_req_t wb_req;
  adcpt_ana_t ana;
  int error_cnt = 0;
  int num_checks = 0;
  int pc = 0, ac = 0, sc = 0, dc = 0, tk = 0, rcc = 0, cyc = 0;

  adcpt_core dut (.clock(clock), .rst_b(rst_b), .wb_req(wb_req),
    .ack_o(ack_o), .dat_o(dat_o), .trigger_i(trigger_i),
    .conv_done_i(conv_done_i), .conv_data_i(conv_data_i),
    .rc_osc_pin(rc_osc_pin), .ana(ana), .irq(irq));
  adcpt_ana_model model (.clock(clock), .rst_b(rst_b), .ana(ana),
    .lat(lat), .sample(sample), .conv_done_i(conv_done_i),
    .conv_data_i(conv_data_i));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // ==========
  // Monitor, RC pin (period 6 clocks) and watchdog
  always @(posedge clock) begin
    pc <= pc + ana.precharge;
    ac <= ac + ana.acquire;
    sc <= sc + ana.convert_start;
    dc <= dc + conv_done_i;
    tk <= tk + ana.adc_clk_tick;
    seen <= ana.convert_start ? 1'b0 : seen | ana.acquire;
    bad <= bad | (ana.precharge & seen) |
      (ana.convert_start & (ana.precharge | ana.acquire));
    rcc <= (rcc == 2) ? 0 : rcc + 1;
    if (rcc == 2) rc_osc_pin <= ~rc_osc_pin;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      $display("timeout");
      complete_run();
    end
  end

  // ==========
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [15:0] fmt(input logic [9:0] d);
    return ctl[CTRL_FMT] ? {d, 6'h00} : {6'h00, d};
  endfunction

  task automatic chk(input string n, input logic [15:0] e,
      input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic chkn(input string n, input int e, input int g,
      input int t);
    num_checks++;
    if (g < e - t || g > e + t) begin
      error_cnt++;
      $display("wrong value %s exp %0d got %0d", n, e, g);
    end
  endtask

  task automatic tend(input string n);
    $display("test %s done", n);
  endtask

  // Classic cycle: hold until ack is sampled, then one idle cycle
  task automatic bus(input logic w, input logic [13:0] i,
      input logic [7:0] d);
    int n;
    n = 0;
    wb_req <= '{1'b1, 1'b1, w, {i, 2'b00}, {24'h000000, d}, 4'hF};
    do begin
      @(posedge clock);
      n++;
    end while (ack_o !== 1'b1 && n < 40);
    chkn("ack", 1, int'(n < 40), 0);
    q = dat_o[7:0];
    wb_req <= '0;
    @(posedge clock);
  endtask

  task automatic r16(input logic [13:0] i);
    bus(1'b0, i, 8'h00);
    f[7:0] = q;
    bus(1'b0, i + 14'h0001, 8'h00);
    f[15:8] = q;
  endtask

  task automatic w16(input logic [13:0] i, input logic [15:0] d);
    bus(1'b1, i, d[7:0]);
    bus(1'b1, i + 14'h0001, d[15:8]);
  endtask

  task automatic pulse();
    trigger_i <= 1'b1;
    @(posedge clock);
    trigger_i <= 1'b0;
  endtask

  task automatic fchk(input int s);
    ef = 16'(acc >>> s);
    r16(IDX_FLT_L);
    chk("filt", ef, f);
  endtask

  // One conversion; a second trigger while busy must be ignored
  task automatic conv(input logic [12:0] pre, input logic [12:0] sampling_window,
      input logic [9:0] d, input int t);
    int p0, a0, s0, d0, n, tl, ea;
    logic [15:0] ep;
    p0 = pc;
    a0 = ac;
    s0 = sc;
    d0 = dc;
    n = 0;
    tl = (t > 1) ? t : 0;
    ea = (sampling_window == 0 && pre != 0) ? 8192 : int'(sampling_window);
    ep = ctl[CTRL_PRIOR_SOURCE_SEL] ? ef : lres;
    w16(IDX_PRE_L, {3'h0, pre});
    w16(IDX_ACQ_L, {3'h0, sampling_window});
    sample <= d;
    lat <= 8'(32'd12 + rnd() % 32'd40);
    if (d[0]) bus(1'b1, IDX_CTRL, ctl | 8'h01);
    else pulse();
    repeat (2) @(posedge clock);
    pulse();
    while (dc == d0 && n < 20000) begin
      @(posedge clock);
      n++;
    end
    repeat (4) @(posedge clock);
    chkn("pre", int'(pre) * t, pc - p0, tl);
    chkn("acq", ea * t, ac - a0, tl);
    chkn("starts", 1, sc - s0, 0);
    chk("order", 16'h0000, {15'h0000, bad});
    r16(IDX_PREV_L);
    chk("prior", ep, f);
    lres = fmt(d);
    r16(IDX_RES_L);
    chk("result", lres, f);
  endtask

  task automatic cv();
    v = 16'(rnd() % 32'd1024);
    conv(13'h0001, 13'h0001, v[9:0], 1);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========
  // Main sequence
  initial begin
    logic [13:0] ri[11];
    logic [12:0] pt[5], at[5];
    logic [7:0] c;
    int s0, d0, n;
    ri = '{IDX_CNT, IDX_RPT, IDX_PREV_L, IDX_PREV_H, IDX_RES_L,
      IDX_RES_H, IDX_ACQ_L, IDX_ACQ_H, IDX_CAP, IDX_INT_ST, 14'h1D00};
    pt = '{13'h0003, 13'h0000, 13'h0000, 13'h0001, 13'h0002};
    at = '{13'h0002, 13'h0005, 13'h0000, 13'h0000, 13'h0001};
    rst_b = 1'b0;
    wb_req = '0;
    trigger_i = 1'b0;
    rc_osc_pin = 1'b0;
    lat = 8'h0C;
    sample = 10'h000;
    ctl = 8'h00;
    ef = 16'h0000;
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    foreach (ri[k]) begin
      bus(1'b0, ri[k], 8'h00);
      chk("reset", 16'h0000, {8'h00, q});
    end
    bus(1'b1, IDX_CLKDIV, 8'h02);
    s0 = tk;
    repeat (120) @(posedge clock);
    chkn("ticks", 20, tk - s0, 1);
    tend("reset");
    for (int k = 0; k < 6; k++) begin
      v = 16'(rnd());
      c = (k == 0) ? 8'h00 : (k == 1) ? 8'h1F : v[15:8];
      w16(IDX_RES_L, v);
      r16(IDX_RES_L);
      chk("res rw", v, f);
      w16(IDX_ACQ_L, v);
      r16(IDX_ACQ_L);
      chk("acq rw", {3'h0, v[12:0]}, f);
      bus(1'b1, IDX_CAP, c);
      @(posedge clock);
      chk("load", {11'h000, c[4:0]}, {11'h000, ana.added_load});
      bus(1'b1, IDX_RPT, v[7:0]);
      bus(1'b0, IDX_RPT, 8'h00);
      chk("repeat", {8'h00, v[7:0]}, {8'h00, q});
      lres = v;
    end
    tend("registers");
    for (int k = 0; k < 6; k++) begin
      if (k < 5) conv(pt[k], at[k], 10'(rnd()), 1);
      else conv(13'(1 + rnd() % 32'd40), 13'(1 + rnd() % 32'd40),
        10'(rnd()), 1);
    end
    bus(1'b0, IDX_CNT, 8'h00);
    chk("tally basic", 16'h0000, {8'h00, q});
    ctl = 8'h08;
    bus(1'b1, IDX_CTRL, ctl);
    conv(13'h0002, 13'h0003, 10'(rnd()), 1);
    ctl = 8'h02;
    bus(1'b1, IDX_CTRL, ctl);
    conv(13'h0003, 13'h0002, 10'(rnd()), 6);
    tend("phases");
    ctl = 8'h00;
    bus(1'b1, IDX_CTRL, ctl);
    bus(1'b1, IDX_COMP, 8'h12);
    bus(1'b1, IDX_RPT, 8'h02);
    bus(1'b1, IDX_CNT, 8'h00);
    cv();
    acc = 18'(v);
    fchk(1);
    bus(1'b0, IDX_CNT, 8'h00);
    chk("tally", 16'h0001, {8'h00, q});
    ctl = 8'h04;
    bus(1'b1, IDX_CTRL, ctl);
    cv();
    acc = acc + 18'(v);
    fchk(1);
    bus(1'b0, IDX_CNT, 8'h00);
    chk("tally", 16'h0000, {8'h00, q});
    bus(1'b0, IDX_INT_ST, 8'h00);
    chk("thr flag", 16'h0001, {15'h0000, q[INT_THR]});
    bus(1'b1, IDX_FLT_L, ~ef[7:0]);
    r16(IDX_FLT_L);
    chk("filt ro", ef, f);
    bus(1'b1, IDX_COMP, 8'h24);
    // Filtered value follows the new shift at once
    ef = 16'(acc >>> 2);
    cv();
    acc = acc + 18'(v) - (acc >>> 2);
    fchk(2);
    bus(1'b1, IDX_COMP, 8'h01);
    ef = 16'(acc);
    cv();
    acc = acc + 18'(v);
    fchk(0);
    tend("computation");
    bus(1'b1, IDX_COMP, 8'h03);
    bus(1'b1, IDX_CNT, 8'h00);
    bus(1'b1, IDX_INT_CLR, 8'h03);
    s0 = sc;
    d0 = dc;
    n = 0;
    bus(1'b1, IDX_CTRL, ctl | 8'h01);
    while (dc < d0 + 2 && n < 5000) begin
      @(posedge clock);
      n++;
    end
    repeat (200) @(posedge clock);
    chkn("burst", 2, sc - s0, 0);
    acc = 18'(v) + 18'(v);
    fchk(0);
    bus(1'b0, IDX_INT_ST, 8'h00);
    chk("thr flag", 16'h0001, {15'h0000, q[INT_THR]});
    tend("burst");
    bus(1'b1, IDX_COMP, 8'h00);
    bus(1'b1, IDX_INT_CLR, 8'h03);
    bus(1'b0, IDX_INT_ST, 8'h00);
    chk("status", 16'h0000, {8'h00, q});
    bus(1'b1, IDX_INT_EN, 8'h01);
    chk("irq", 16'h0000, {15'h0000, irq});
    cv();
    chk("irq", 16'h0001, {15'h0000, irq});
    bus(1'b1, IDX_INT_EN, 8'h00);
    @(posedge clock);
    chk("irq", 16'h0000, {15'h0000, irq});
    bus(1'b1, IDX_INT_EN, 8'h01);
    bus(1'b1, IDX_INT_CLR, 8'h01);
    @(posedge clock);
    chk("irq", 16'h0000, {15'h0000, irq});
    bus(1'b0, IDX_INT_CLR, 8'h00);
    chk("clr reg", 16'h0000, {8'h00, q});
    tend("interrupts");
    complete_run();
  end
endmodule // adcpt_core_tb
`default_nettype wire
